//--- verilog/xor_dir_pkg.sv
// constants for the exclusive-or and direction-load execute block
package xor_dir_pkg;
  localparam int unsigned INSN_W     = 12;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FADDR_W    = 5;
  localparam int unsigned FILE_DEPTH = 32;
  // instruction patterns
  localparam logic [8:0]  DIR_LOAD_TOP    = 9'h000;
  localparam logic [2:0]  DIR_PORT_INDEX  = 3'h6;
  localparam logic [5:0]  FILE_XOR_TOP    = 6'h06;
  localparam logic [3:0]  IMM_XOR_TOP     = 4'hF;
  // field positions
  localparam int unsigned DEST_BIT        = 5;
  // reset values
  localparam logic [7:0]  ACC_RESET       = 8'h00;
  localparam logic [7:0]  DIR_RESET       = 8'hFF;
  localparam logic [7:0]  FILE_RESET      = 8'h00;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_DIR_LOAD,
    OP_FILE_XOR,
    OP_IMM_XOR
  } op_t;
endpackage

//--- verilog/file_reg_mem.sv
// small file-register memory with registered read data
module file_reg_mem #(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW    = 5,
  parameter int unsigned DW    = 8
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_rst_n,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata
);
  logic [DW-1:0] mem_q [DEPTH];
  logic [DW-1:0] rdata_d;

  always_comb
  begin
    rdata_d = mem_q[i_raddr];
    // write-through keeps a read after a write in the same cycle coherent
    if (i_we && (i_waddr == i_raddr))
    begin
      rdata_d = i_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= xor_dir_pkg::FILE_RESET;
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= xor_dir_pkg::FILE_RESET;
      end
    end
    else
    begin
      o_rdata <= rdata_d;
      if (i_we)
      begin
        mem_q[i_waddr] <= i_wdata;
      end
    end
  end
endmodule

//--- verilog/xor_dir_exec.sv
// decode and execute of direction load, file and immediate exclusive-or
module xor_dir_exec #(
  parameter int unsigned DATA_W  = xor_dir_pkg::DATA_W,
  parameter int unsigned FADDR_W = xor_dir_pkg::FADDR_W
) (
  input  wire logic                            i_core_clk,
  input  wire logic                            i_rst_n,
  input  wire logic                            i_insn_valid,
  input  wire logic [xor_dir_pkg::INSN_W-1:0]  i_insn,
  input  wire logic [FADDR_W-1:0]              i_faddr_next,
  output logic                                 o_insn_ready,
  output logic      [DATA_W-1:0]               o_acc,
  output logic      [DATA_W-1:0]               o_pin_dir,
  output logic                                 o_zero,
  output logic                                 o_file_we,
  output logic      [FADDR_W-1:0]              o_file_addr,
  output logic      [DATA_W-1:0]               o_file_wdata,
  output logic                                 o_bad_insn
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // every instruction here completes in one cycle, so the core never stalls
  assign o_insn_ready = 1'b1;

  function automatic xor_dir_pkg::op_t decode(input logic [xor_dir_pkg::INSN_W-1:0] w);
    xor_dir_pkg::op_t op;
    op = xor_dir_pkg::OP_NONE;
    if (w[11:3] == xor_dir_pkg::DIR_LOAD_TOP && w[2:0] != 3'h0)
    begin
      op = xor_dir_pkg::OP_DIR_LOAD;
    end
    else if (w[11:6] == xor_dir_pkg::FILE_XOR_TOP)
    begin
      op = xor_dir_pkg::OP_FILE_XOR;
    end
    else if (w[11:8] == xor_dir_pkg::IMM_XOR_TOP)
    begin
      op = xor_dir_pkg::OP_IMM_XOR;
    end
    return op;
  endfunction

  xor_dir_pkg::op_t op;
  logic [DATA_W-1:0] file_rdata;
  logic [DATA_W-1:0] result;
  logic              dest_file;

  assign op        = i_insn_valid ? decode(i_insn) : xor_dir_pkg::OP_NONE;
  assign dest_file = i_insn[xor_dir_pkg::DEST_BIT];

  // ----------------------------------------------------------------
  // file register storage
  // ----------------------------------------------------------------
  // read address is presented one cycle early by the fetch stage, so the
  // registered read data lines up with the instruction word
  file_reg_mem #(
    .DEPTH (xor_dir_pkg::FILE_DEPTH),
    .AW    (FADDR_W),
    .DW    (DATA_W)
  ) u_file (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_raddr    (i_faddr_next),
    .o_rdata    (file_rdata),
    .i_we       (o_file_we),
    .i_waddr    (o_file_addr),
    .i_wdata    (o_file_wdata)
  );

  // ----------------------------------------------------------------
  // execute
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] acc_d;
  logic [DATA_W-1:0] dir_d;
  logic              zero_d;
  logic              bad_d;

  always_comb
  begin
    acc_d        = o_acc;
    dir_d        = o_pin_dir;
    zero_d       = o_zero;
    bad_d        = 1'b0;
    result       = '0;
    o_file_we    = 1'b0;
    o_file_addr  = i_insn[FADDR_W-1:0];
    o_file_wdata = '0;
    case (op)
      xor_dir_pkg::OP_DIR_LOAD:
      begin
        if (i_insn[2:0] == xor_dir_pkg::DIR_PORT_INDEX)
        begin
          dir_d = o_acc;
        end
        else
        begin
          // other indices have no direction register: ignored, flagged
          bad_d = 1'b1;
        end
      end
      xor_dir_pkg::OP_FILE_XOR:
      begin
        result = o_acc ^ file_rdata;
        zero_d = (result == '0);
        if (dest_file)
        begin
          o_file_we    = 1'b1;
          o_file_wdata = result;
        end
        else
        begin
          acc_d = result;
        end
      end
      xor_dir_pkg::OP_IMM_XOR:
      begin
        result = o_acc ^ i_insn[DATA_W-1:0];
        acc_d  = result;
        zero_d = (result == '0);
      end
      default:
      begin
        bad_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_acc      <= xor_dir_pkg::ACC_RESET;
      o_pin_dir  <= xor_dir_pkg::DIR_RESET;
      o_zero     <= 1'b0;
      o_bad_insn <= 1'b0;
    end
    else
    begin
      o_acc      <= acc_d;
      o_pin_dir  <= dir_d;
      o_zero     <= zero_d;
      o_bad_insn <= bad_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_dir_load;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (op == xor_dir_pkg::OP_DIR_LOAD && i_insn[2:0] == xor_dir_pkg::DIR_PORT_INDEX)
      |=> (o_pin_dir == $past(o_acc)) && $stable(o_zero);
  endproperty
  a_dir_load: assert property (p_dir_load) else $error("direction load wrong");

  property p_dir_bad_index;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (op == xor_dir_pkg::OP_DIR_LOAD && i_insn[2:0] != xor_dir_pkg::DIR_PORT_INDEX)
      |=> $stable(o_pin_dir) && o_bad_insn;
  endproperty
  a_dir_bad_index: assert property (p_dir_bad_index) else $error("bad index took");

  property p_file_zero;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (op == xor_dir_pkg::OP_FILE_XOR) |=> o_zero == ($past(o_acc ^ file_rdata) == '0);
  endproperty
  a_file_zero: assert property (p_file_zero) else $error("file xor zero wrong");

  property p_dest_acc;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (op == xor_dir_pkg::OP_FILE_XOR && !dest_file)
      |-> !o_file_we ##1 o_acc == $past(o_acc ^ file_rdata);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("dest 0 wrong");

  property p_dest_file;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (op == xor_dir_pkg::OP_FILE_XOR && dest_file)
      |-> o_file_we && o_file_wdata == (o_acc ^ file_rdata) ##1 $stable(o_acc);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("dest 1 wrong");

  property p_imm;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (op == xor_dir_pkg::OP_IMM_XOR)
      |=> o_acc == ($past(o_acc) ^ $past(i_insn[7:0])) && o_zero == (o_acc == '0);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate xor wrong");

  property p_idle_hold;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (op == xor_dir_pkg::OP_NONE) |=> $stable(o_acc) && $stable(o_pin_dir) && $stable(o_zero);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("state moved when idle");

  property p_no_stray_write;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    o_file_we |-> (op == xor_dir_pkg::OP_FILE_XOR && dest_file);
  endproperty
  a_no_stray_write: assert property (p_no_stray_write) else $error("stray file write");

  c_dir_load: cover property (@(posedge i_core_clk) op == xor_dir_pkg::OP_DIR_LOAD);
  c_file_acc: cover property (@(posedge i_core_clk) op == xor_dir_pkg::OP_FILE_XOR && !dest_file);
  c_file_mem: cover property (@(posedge i_core_clk) o_file_we);
  c_imm_zero: cover property (@(posedge i_core_clk) op == xor_dir_pkg::OP_IMM_XOR ##1 o_zero);
endmodule

//--- test/prog_mem_model.sv
// program memory model feeding instruction words to the execute block
module prog_mem_model
(
  input  wire logic        i_en,
  input  wire logic [3:0]  i_pc,
  output logic             o_valid,
  output logic      [11:0] o_insn,
  output logic      [4:0]  o_faddr_next
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // program image
  // ---------------------------------------------------------------
  localparam logic [11:0] ROM [16] = '{
    12'hFB5, 12'h1A3, 12'h183, 12'h006, 12'hFAF, 12'h1A3, 12'h006, 12'h005,
    12'h183, 12'h000, 12'hFB5, 12'h007, 12'h006, 12'h000, 12'h000, 12'h000};
  logic [3:0] next_pc;
  assign next_pc      = i_pc + 4'h1;
  assign o_valid      = i_en;
  // idle word is inverted so that gating on valid is really exercised
  assign o_insn       = i_en ? ROM[i_pc] : ~ROM[i_pc];
  // read address runs one word ahead while enabled, and sits on the current word when idle, because file read data is registered
  assign o_faddr_next = i_en ? ROM[next_pc][4:0] : ROM[i_pc][4:0];
endmodule

//--- test/tb.sv
// self-checking bench for the exclusive-or and direction-load execute block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] dir;
    logic       zero;
    logic       bad;
    logic       we;
    logic [7:0] wdata;
  } row_t;
  logic        i_core_clk = 1'h0;
  logic        i_rst_n    = 1'h0;
  logic        en         = 1'h0;
  logic [3:0]  pc         = 4'h0;
  logic        valid;
  logic [11:0] insn;
  logic [4:0]  faddr_next;
  logic        ready;
  logic        zero;
  logic        file_we;
  logic        bad;
  logic [7:0]  acc;
  logic [7:0]  pin_dir;
  logic [7:0]  file_wdata;
  logic [4:0]  file_addr;
  int          errors   = 0;
  int          compares = 0;
  row_t        rows [13];

  always #5 i_core_clk = ~i_core_clk;

  prog_mem_model u_prog (.i_en(en), .i_pc(pc), .o_valid(valid), .o_insn(insn),
                         .o_faddr_next(faddr_next));

  xor_dir_exec u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_insn_valid(valid),
    .i_insn(insn), .i_faddr_next(faddr_next), .o_insn_ready(ready), .o_acc(acc),
    .o_pin_dir(pin_dir), .o_zero(zero), .o_file_we(file_we), .o_file_addr(file_addr),
    .o_file_wdata(file_wdata), .o_bad_insn(bad));

  // ---------------------------------------------------------------
  // compare and report
  // ---------------------------------------------------------------
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    // expected state after each program word, write port during it
    rows = '{
      '{8'hB5, 8'hFF, 1'h0, 1'h0, 1'h0, 8'h00},
      '{8'hB5, 8'hFF, 1'h0, 1'h0, 1'h1, 8'hB5},
      '{8'h00, 8'hFF, 1'h1, 1'h0, 1'h0, 8'h00},
      '{8'h00, 8'h00, 1'h1, 1'h0, 1'h0, 8'h00},
      '{8'hAF, 8'h00, 1'h0, 1'h0, 1'h0, 8'h00},
      '{8'hAF, 8'h00, 1'h0, 1'h0, 1'h1, 8'h1A},
      '{8'hAF, 8'hAF, 1'h0, 1'h0, 1'h0, 8'h00},
      '{8'hAF, 8'hAF, 1'h0, 1'h1, 1'h0, 8'h00},
      '{8'hB5, 8'hAF, 1'h0, 1'h0, 1'h0, 8'h00},
      '{8'hB5, 8'hAF, 1'h0, 1'h0, 1'h0, 8'h00},
      '{8'h00, 8'hAF, 1'h1, 1'h0, 1'h0, 8'h00},
      '{8'h00, 8'hAF, 1'h1, 1'h1, 1'h0, 8'h00},
      '{8'h00, 8'h00, 1'h1, 1'h0, 1'h0, 8'h00}};
    repeat (20) @(negedge i_core_clk);
    cmp8(acc, 8'h00);
    cmp8(pin_dir, 8'hFF);
    cmp1(zero, 1'h0);
    cmp1(file_we, 1'h0);
    i_rst_n = 1'h1;
    en      = 1'h1;
    for (int i = 0; i < 13; i++)
    begin
      pc = 4'(i);
      #1;
      cmp1(ready, 1'h1);
      cmp1(file_we, rows[i].we);
      cmp8(file_wdata, rows[i].wdata);
      if (rows[i].we === 1'h1)
        cmp8({3'h0, file_addr}, 8'h03);
      @(negedge i_core_clk);
      cmp8(acc, rows[i].acc);
      cmp8(pin_dir, rows[i].dir);
      cmp1(zero, rows[i].zero);
      cmp1(bad, rows[i].bad);
    end
    // idle words must not execute
    en = 1'h0;
    repeat (3) @(negedge i_core_clk);
    cmp8(acc, 8'h00);
    cmp1(zero, 1'h1);
    cmp8(pin_dir, 8'h00);
    // reset again in mid-run, seen without a clock edge
    i_rst_n = 1'h0;
    #1;
    cmp8(acc, 8'h00);
    cmp8(pin_dir, 8'hFF);
    cmp1(zero, 1'h0);
    cmp1(bad, 1'h0);
    // release while idle on word 2, so its file read is primed one cycle ahead
    repeat (2) @(negedge i_core_clk);
    pc      = 4'h2;
    i_rst_n = 1'h1;
    @(negedge i_core_clk);
    en = 1'h1;
    @(negedge i_core_clk);
    en = 1'h0;
    // file register 3 held 1A before reset: a zero result shows it was cleared
    cmp8(acc, 8'h00);
    cmp1(zero, 1'h1);
    cmp8(pin_dir, 8'hFF);
    summarize();
  end
endmodule
